// *** design/hpc_cfg.svh ***
// Offsets, field positions, reset values and counts of the hibernation block
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// -----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// -----------------------------------------------------------------
`define HPC_OFS_CTRL 8'h00
`define HPC_OFS_BATTERY 8'h04
`define HPC_OFS_MASK 8'h08
`define HPC_OFS_RAW 8'h0C
`define HPC_OFS_MASKED 8'h10
`define HPC_OFS_CLEAR 8'h14
`define HPC_OFS_COUNT 8'h18
`define HPC_OFS_MATCH 8'h1C
`define HPC_OFS_WAKE 8'h20
`define HPC_MEM_PAGE 2'h1

// -----------------------------------------------------------------
// Control register bits
// -----------------------------------------------------------------
`define HPC_CTRL_ACTIVE 0
`define HPC_CTRL_RTC_EN 1
`define HPC_CTRL_HIB_REQ 2
`define HPC_CTRL_WR_BUSY 3

// -----------------------------------------------------------------
// Interrupt source bit positions, same in raw, masked, mask, clear
// -----------------------------------------------------------------
`define HPC_IRQ_WR_COMPLETE 0
`define HPC_IRQ_PIN_WAKE 1
`define HPC_IRQ_BATTERY_LOW 2
`define HPC_IRQ_RTC_MATCH0 3
`define HPC_IRQ_SUPPLY_FAIL 4
`define HPC_IRQ_RESET_WAKE 5
`define HPC_IRQ_GPIO_WAKE 6
`define HPC_IRQ_W 7

// -----------------------------------------------------------------
// Battery configuration fields and codes
// -----------------------------------------------------------------
`define HPC_BATTERY_MODE_LO 0
`define HPC_BATTERY_MODE_HI 1
`define HPC_BATTERY_THR_LO 2
`define HPC_BATTERY_THR_HI 3
`define HPC_BATTERY_OFF 2'h0
`define HPC_BATTERY_DETECT_ONLY 2'h1
`define HPC_BATTERY_DETECT_ABORT 2'h2
`define HPC_BATTERY_THRESHOLD_LOWEST 2'h0
`define HPC_BATTERY_THRESHOLD_SECOND 2'h1
`define HPC_BATTERY_THRESHOLD_THIRD 2'h2
`define HPC_BATTERY_THRESHOLD_HIGHEST 2'h3

// -----------------------------------------------------------------
// Wake configuration bits
// -----------------------------------------------------------------
`define HPC_WAKE_PIN 0
`define HPC_WAKE_RTC 1
`define HPC_WAKE_RESET 2
`define HPC_WAKE_GPIO 3

// -----------------------------------------------------------------
// Counts and reset values
// -----------------------------------------------------------------
`define HPC_TB_DIV 32768
`define HPC_WC_CYCLES 4'h3
`define HPC_ZERO32 32'h0000_0000

`endif

// *** design/hpc_pkg.sv ***
// Types shared by the hibernation block modules
package hpc_pkg;

  // Power state of the main domain
  typedef enum logic {HPC_RUN, HPC_HIB} hpc_pwr_state_t;

  // Whole state of the control module
  typedef struct packed {
    hpc_pwr_state_t state;
    logic reg_en;
    logic active;
    logic rtc_en;
    logic [3:0] busy;
    logic [1:0] bat_mode;
    logic [1:0] bat_thr;
    logic [6:0] mask;
    logic [6:0] raw;
    logic [3:0] wake_cfg;
    logic [31:0] match;
    logic rtc_load;
    logic [31:0] load_val;
    logic [4:0] prev;
    logic [31:0] rdata;
    logic irq;
    logic [15:0][31:0] mem;
  } hpc_ctl_state_t;

  // Whole state of the counter module
  typedef struct packed {
    logic [31:0] count;
    logic [15:0] pre;
    logic match;
  } hpc_rtc_state_t;

endpackage : hpc_pkg

// *** design/hpc_rtc_if.sv ***
// Signals between the control module and the real-time counter
`timescale 1ns/1ns
interface hpc_rtc_if;
  logic en;
  logic tb_edge;
  logic load;
  logic [31:0] load_val;
  logic [31:0] match_val;
  logic [31:0] count;
  logic match;

  modport ctl (
    output en,
    output tb_edge,
    output load,
    output load_val,
    output match_val,
    input count,
    input match
  );

  modport rtc (
    input en,
    input tb_edge,
    input load,
    input load_val,
    input match_val,
    output count,
    output match
  );
endinterface : hpc_rtc_if

// *** design/hpc_sync.sv ***
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module hpc_sync #(
  parameter int unsigned W = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // -----------------------------------------------------------------
  // One pair of flops per pin
  // -----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_q;
      logic sync_q;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else if (ce) begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate

endmodule : hpc_sync

// *** design/hpc_rtc.sv ***
// Seconds counter with prescaler and match flag
`timescale 1ns/1ns
`include "hpc_cfg.svh"
module hpc_rtc
  import hpc_pkg::*;
#(
  parameter int unsigned DIV = `HPC_TB_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  hpc_rtc_if.rtc r
);

  localparam logic [15:0] DIV_LAST = 16'(DIV - 1);

  hpc_rtc_state_t q;
  hpc_rtc_state_t d;

  // Next state: load, prescale, advance, compare
  always_comb begin
    d = q;
    d.match = 1'b0;
    if (!r.en) begin
      d.pre = 16'h0000; // Counting stopped
    end else if (r.load) begin
      d.count = r.load_val;
      d.pre = 16'h0000;
    end else if (r.tb_edge) begin
      if (q.pre == DIV_LAST) begin
        d.pre = 16'h0000;
        d.count = q.count + 32'h0000_0001; // One second
        d.match = (d.count == r.match_val);
      end else begin
        d.pre = q.pre + 16'h0001;
      end
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign r.count = q.count;
  assign r.match = q.match;

endmodule : hpc_rtc

// *** design/hpc_top.sv ***
// Hibernation power controller: regulator enable, wake, status, counter
// What this block does
// - Seven interrupt sources, any mix of them enabled together.
// - Enable mask per source gates masked status and interrupt request.
// - Raw and masked status readable, same bit positions.
// - Control register shows the module is already active.
// - Battery below chosen threshold with detection on sets raw bit.
// - Detect-only or detect-and-abort; abort keeps regulator on.
// - Four thresholds, 1.9, 2.1, 2.3, 2.5 V, beside the mode.
// - Hibernation request drops the regulator enable; this logic stays up.
// - Any configured wake condition raises the regulator enable again.
// - Processor reset leaves this logic and its state untouched.
// - Counter enable off stops counting, match wake and match interrupt.
// - Enabled counter events may wake, interrupt, or both.
// - Counter value readable by software.
// - Counter advances once a second from the 32.768 kHz time base.
// - Counter equal to match value flags the match.
// - Sixteen 32-bit words of storage kept while power is off.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ns
`include "hpc_cfg.svh"
module hpc_top
  import hpc_pkg::*;
#(
  parameter int unsigned TB_DIV = `HPC_TB_DIV,
  parameter logic [3:0] WC_CYCLES = `HPC_WC_CYCLES
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  input wire logic TB_CLK,
  input wire logic WAKE,
  input wire logic RESET_WAKE,
  input wire logic GPIO_WAKE,
  input wire logic SUPPLY_FAIL,
  input wire logic [3:0] BATTERY_BELOW,
  output logic REG_EN,
  output logic IRQ
);

  // -----------------------------------------------------------------
  // Reset release
  // -----------------------------------------------------------------

  // Battery-side reset only; the processor reset never enters here
  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // -----------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------

  logic [8:0] pin_raw;
  logic [8:0] pin_s;

  // Order: time base, wake, reset wake, gpio wake, supply fail, battery
  assign pin_raw = {BATTERY_BELOW, SUPPLY_FAIL, GPIO_WAKE, RESET_WAKE,
                    WAKE, TB_CLK};

  hpc_sync #(
    .W(9)
  ) u_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .din(pin_raw),
    .dout(pin_s)
  );

  // -----------------------------------------------------------------
  // State and counter
  // -----------------------------------------------------------------

  hpc_ctl_state_t q;
  hpc_ctl_state_t d;
  hpc_rtc_if rtc_bus ();

  hpc_rtc #(
    .DIV(TB_DIV)
  ) u_rtc (
    .clk(CLK),
    .rst_n(rst_n),
    .ce(CE),
    .r(rtc_bus)
  );

  // Counter controls come straight from registers, except the time-base edge, decoded from the synchronised pin
  assign rtc_bus.en = q.rtc_en;
  assign rtc_bus.tb_edge = pin_s[0] & ~q.prev[0];
  assign rtc_bus.load = q.rtc_load;
  assign rtc_bus.load_val = q.load_val;
  assign rtc_bus.match_val = q.match;

  // -----------------------------------------------------------------
  // Events
  // -----------------------------------------------------------------

  logic [4:0] rise;
  logic [3:0] below;
  logic battery_low;
  logic wc_done;
  logic [6:0] ev;
  logic [6:0] clr;
  logic wake_hit;
  logic hib_go;
  logic wr_slow;

  // Rising edges of the synchronised pins
  assign rise = pin_s[4:0] & ~q.prev;
  assign below = pin_s[8:5];

  // Comparator output picked by the threshold field
  assign battery_low = (q.bat_mode != `HPC_BATTERY_OFF) &&
                       below[q.bat_thr];

  // Slow-domain write finished on the last busy cycle
  assign wc_done = (q.busy == 4'h1);

  // One event bit per source
  assign ev[`HPC_IRQ_WR_COMPLETE] = wc_done;
  assign ev[`HPC_IRQ_PIN_WAKE] = rise[1];
  assign ev[`HPC_IRQ_BATTERY_LOW] = battery_low;
  assign ev[`HPC_IRQ_RTC_MATCH0] = rtc_bus.match;
  assign ev[`HPC_IRQ_SUPPLY_FAIL] = rise[4];
  assign ev[`HPC_IRQ_RESET_WAKE] = rise[2];
  assign ev[`HPC_IRQ_GPIO_WAKE] = rise[3];

  // Write-one-to-clear request
  assign clr = (WR && ADDR == `HPC_OFS_CLEAR) ? WDATA[6:0] : 7'h00;

  // Any configured wake condition
  assign wake_hit = (q.wake_cfg[`HPC_WAKE_PIN] & rise[1]) |
                    (q.wake_cfg[`HPC_WAKE_RTC] & rtc_bus.match) |
                    (q.wake_cfg[`HPC_WAKE_RESET] & rise[2]) |
                    (q.wake_cfg[`HPC_WAKE_GPIO] & rise[3]);

  // Hibernation request, refused in abort mode on a low battery
  assign hib_go = WR && (ADDR == `HPC_OFS_CTRL) &&
                  WDATA[`HPC_CTRL_HIB_REQ] && q.active &&
                  !((q.bat_mode == `HPC_BATTERY_DETECT_ABORT) &&
                    battery_low);

  // Writes that land in the slow time-base registers
  assign wr_slow = WR && (ADDR == `HPC_OFS_CTRL ||
                          ADDR == `HPC_OFS_COUNT ||
                          ADDR == `HPC_OFS_MATCH ||
                          ADDR == `HPC_OFS_BATTERY ||
                          ADDR == `HPC_OFS_WAKE);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------

  always_comb begin
    d = q;
    d.rdata = `HPC_ZERO32;
    d.rtc_load = 1'b0;
    d.prev = pin_s[4:0];

    // Sticky raw status, a new event beats a clear
    d.raw = (q.raw & ~clr) | ev;

    // Write-complete countdown
    if (q.busy != 4'h0) begin
      d.busy = q.busy - 4'h1;
    end
    if (wr_slow) begin
      d.busy = WC_CYCLES;
    end

    // Register writes
    if (WR) begin
      case (ADDR)
        `HPC_OFS_CTRL: begin
          d.active = WDATA[`HPC_CTRL_ACTIVE];
          d.rtc_en = WDATA[`HPC_CTRL_RTC_EN];
        end
        `HPC_OFS_BATTERY: begin
          d.bat_mode = WDATA[`HPC_BATTERY_MODE_HI:`HPC_BATTERY_MODE_LO];
          d.bat_thr = WDATA[`HPC_BATTERY_THR_HI:`HPC_BATTERY_THR_LO];
        end
        `HPC_OFS_MASK: begin
          d.mask = WDATA[6:0];
        end
        `HPC_OFS_COUNT: begin
          d.rtc_load = 1'b1;
          d.load_val = WDATA;
        end
        `HPC_OFS_MATCH: begin
          d.match = WDATA;
        end
        `HPC_OFS_WAKE: begin
          d.wake_cfg = WDATA[3:0];
        end
        default: begin
          if (ADDR[7:6] == `HPC_MEM_PAGE) begin
            d.mem[ADDR[5:2]] = WDATA;
          end
        end
      endcase
    end

    // Register reads, data in the following cycle only
    if (RD) begin
      case (ADDR)
        `HPC_OFS_CTRL: begin
          d.rdata[`HPC_CTRL_ACTIVE] = q.active;
          d.rdata[`HPC_CTRL_RTC_EN] = q.rtc_en;
          d.rdata[`HPC_CTRL_WR_BUSY] = (q.busy != 4'h0);
        end
        `HPC_OFS_BATTERY: begin
          d.rdata[`HPC_BATTERY_MODE_HI:`HPC_BATTERY_MODE_LO] = q.bat_mode;
          d.rdata[`HPC_BATTERY_THR_HI:`HPC_BATTERY_THR_LO] = q.bat_thr;
        end
        `HPC_OFS_MASK: begin
          d.rdata[6:0] = q.mask;
        end
        `HPC_OFS_RAW: begin
          d.rdata[6:0] = q.raw;
        end
        `HPC_OFS_MASKED: begin
          d.rdata[6:0] = q.raw & q.mask;
        end
        `HPC_OFS_COUNT: begin
          d.rdata = rtc_bus.count;
        end
        `HPC_OFS_MATCH: begin
          d.rdata = q.match;
        end
        `HPC_OFS_WAKE: begin
          d.rdata[3:0] = q.wake_cfg;
        end
        default: begin
          if (ADDR[7:6] == `HPC_MEM_PAGE) begin
            d.rdata = q.mem[ADDR[5:2]];
          end
        end
      endcase
    end

    // Power sequencing of the external regulator
    unique case (q.state)
      HPC_RUN: begin
        if (hib_go) begin
          d.state = HPC_HIB;
          d.reg_en = 1'b0;
        end
      end
      HPC_HIB: begin
        if (wake_hit) begin
          d.state = HPC_RUN;
          d.reg_en = 1'b1;
        end
      end
    endcase

    // Masked request to the processor
    d.irq = |(d.raw & d.mask);
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------

  // Power on with the regulator enabled
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= HPC_RUN;
      q.reg_en <= 1'b1;
    end else if (CE) begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------

  assign RDATA = q.rdata;
  assign REG_EN = q.reg_en;
  assign IRQ = q.irq;

endmodule : hpc_top

// *** sim/hpc_monitor.sv ***
// Port checker of the hibernation power controller
`timescale 1ns/1ns
`include "hpc_cfg.svh"
module hpc_monitor (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  input wire logic TB_CLK,
  input wire logic WAKE,
  input wire logic RESET_WAKE,
  input wire logic GPIO_WAKE,
  input wire logic SUPPLY_FAIL,
  input wire logic [3:0] BATTERY_BELOW,
  input wire logic REG_EN,
  input wire logic IRQ
);
  logic act_q, rtc_q, wk_q, hib_wr, bat_lo;
  logic [1:0] mode_q, thr_q;
  logic [2:0] bl_q;
  assign hib_wr = WR && ADDR == `HPC_OFS_CTRL && WDATA[`HPC_CTRL_HIB_REQ];
  assign bat_lo = BATTERY_BELOW[thr_q];
  // Shadow of the settings software wrote
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      act_q <= 1'b0;
      rtc_q <= 1'b0;
      wk_q <= 1'b0;
      mode_q <= 2'h0;
      thr_q <= 2'h0;
      bl_q <= 3'h0;
    end else begin
      bl_q <= {bl_q[1:0], bat_lo};
      if (WR && ADDR == `HPC_OFS_CTRL) begin
        act_q <= WDATA[`HPC_CTRL_ACTIVE];
        rtc_q <= WDATA[`HPC_CTRL_RTC_EN];
      end
      if (WR && ADDR == `HPC_OFS_BATTERY) begin
        mode_q <= WDATA[1:0];
        thr_q <= WDATA[3:2];
      end
      if (WR && ADDR == `HPC_OFS_WAKE) begin
        wk_q <= WDATA[`HPC_WAKE_PIN];
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_rdata_idle: assert property (
    !$past(RD) |-> RDATA == 32'h0000_0000) else $error("stray read data");
  a_ctrl_read: assert property (
    RD && ADDR == `HPC_OFS_CTRL |=> RDATA[1:0] == {rtc_q, act_q})
    else $error("control bits read wrong");
  a_battery_read: assert property (
    RD && ADDR == `HPC_OFS_BATTERY |=> RDATA == {28'h000_0000, thr_q, mode_q})
    else $error("battery setting read wrong");
  a_hib_drop: assert property (
    hib_wr && act_q && REG_EN && mode_q != `HPC_BATTERY_DETECT_ABORT
    |=> !REG_EN) else $error("request left regulator on");
  a_drop_cause: assert property (
    $fell(REG_EN) |-> $past(hib_wr)) else $error("regulator dropped unasked");
  a_abort_keep: assert property (
    hib_wr && act_q && REG_EN && mode_q == `HPC_BATTERY_DETECT_ABORT
    && (&bl_q) && bat_lo |=> REG_EN) else $error("abort did not hold power");
  a_wake_pin: assert property (
    !REG_EN && wk_q && $rose(WAKE) |-> ##[1:4] REG_EN)
    else $error("pin wake missed");
  a_irq_masked: assert property (
    WR && ADDR == `HPC_OFS_MASK && WDATA[6:0] == 7'h00 |=> !IRQ)
    else $error("request with empty mask");
  a_reset_power: assert property (
    $rose(NRST) |-> REG_EN ##1 REG_EN) else $error("power off after reset");
endmodule : hpc_monitor

bind hpc_top hpc_monitor i_mon (.CLK, .NRST, .CE, .ADDR, .WDATA, .WR, .RD,
  .RDATA, .TB_CLK, .WAKE, .RESET_WAKE, .GPIO_WAKE, .SUPPLY_FAIL,
  .BATTERY_BELOW, .REG_EN, .IRQ);

// *** sim/hpc_far_model.sv ***
// Far side model: time base, wake and fault pins, battery monitor
`timescale 1ns/1ns
module hpc_far_model (
  input wire logic clk,
  input wire logic [3:0] ev,
  input wire logic [2:0] band,
  output logic tb_clk,
  output logic [3:0] pins,
  output logic [3:0] below
);
  logic [2:0] div_q = 3'h0;
  initial tb_clk = 1'b0;
  initial pins = 4'h0;
  // Slow time base, one period per eight clocks
  always @(posedge clk) begin
    div_q <= div_q + 3'h1;
    tb_clk <= div_q[2];
    pins <= ev;
  end
  // Band counts thresholds above the battery level
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      below[k] = (k + int'(band)) >= 4;
    end
  end
endmodule : hpc_far_model

// *** sim/hpc_top_tb_top.sv ***
// Testbench of the hibernation power controller
`timescale 1ns/1ns
`include "hpc_cfg.svh"
module hpc_top_tb_top;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] NIL = 32'h0000_0000;
  localparam logic [6:0] SRC [4] = '{7'h02, 7'h20, 7'h40, 7'h10};
  logic CLK = 1'b0, NRST = 1'b0, WR = 1'b0, RD = 1'b0;
  logic [7:0] ADDR = 8'h00;
  logic [31:0] WDATA = NIL;
  logic [31:0] RDATA;
  logic [3:0] ev = 4'h0;
  logic [3:0] pins, below;
  logic [2:0] band = 3'h0;
  logic TB_CLK, REG_EN, IRQ;
  logic [6:0] raw;
  int fail_count = 0;
  int checked = 0;
  always #20 CLK = ~CLK;
  hpc_top #(.TB_DIV(4)) i_dut (.CLK, .NRST, .CE(1'b1), .ADDR, .WDATA, .WR,
    .RD, .RDATA, .TB_CLK, .WAKE(pins[0]), .RESET_WAKE(pins[1]),
    .GPIO_WAKE(pins[2]), .SUPPLY_FAIL(pins[3]), .BATTERY_BELOW(below),
    .REG_EN, .IRQ);
  hpc_far_model i_far (.clk(CLK), .ev, .band, .tb_clk(TB_CLK), .pins,
    .below);
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA & m, e);
  endtask : rd
  task automatic pulse(input int k);
    @(posedge CLK);
    ev <= 4'h1 << k;
    idle(2);
    ev <= 4'h0;
  endtask : pulse
  task automatic wait_en(input logic v);
    for (int i = 0; i < 20 && REG_EN !== v; i++) @(posedge CLK);
    chk({31'h0, REG_EN}, {31'h0, v});
  endtask : wait_en
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    idle(16);
    NRST <= 1'b1;
    idle(4);
    rd(`HPC_OFS_CTRL, NIL, ALL);
    rd(`HPC_OFS_RAW, NIL, ALL);
    rd(8'h24, NIL, ALL);
    // Storage words at both ends of the page
    wr(8'h40, 32'hA5A5_5A5A);
    wr(8'h7C, 32'h0123_4567);
    rd(8'h40, 32'hA5A5_5A5A, ALL);
    rd(8'h7C, 32'h0123_4567, ALL);
    wr(`HPC_OFS_CTRL, 32'h0000_0003);
    rd(`HPC_OFS_CTRL, 32'h0000_000B, ALL);
    idle(2);
    rd(`HPC_OFS_RAW, 32'h0000_0001, 32'h0000_0001);
    wr(`HPC_OFS_CLEAR, 32'h0000_007F);
    wr(`HPC_OFS_MASK, 32'h0000_0012);
    raw = 7'h00;
    // Each pin event sets its own raw bit, kept until cleared
    for (int k = 0; k < 4; k++) begin
      pulse(k);
      idle(4);
      raw |= SRC[k];
      rd(`HPC_OFS_RAW, 32'(raw), 32'h0000_007E);
      rd(`HPC_OFS_MASKED, 32'(raw & 7'h12), ALL);
      chk({31'h0, IRQ}, {31'h0, |(raw & 7'h12)});
    end
    wr(`HPC_OFS_MASK, NIL);
    rd(`HPC_OFS_RAW, 32'(raw), 32'h0000_007E);
    chk({31'h0, IRQ}, NIL);
    // Every mode and threshold against a battery between two levels
    band <= 3'h2;
    for (int m = 0; m < 3; m++) begin
      for (int t = 0; t < 4; t++) begin
        wr(`HPC_OFS_BATTERY, 32'(t * 4 + m));
        wr(`HPC_OFS_CLEAR, 32'h0000_007F);
        idle(4);
        rd(`HPC_OFS_BATTERY, 32'(t * 4 + m), ALL);
        rd(`HPC_OFS_RAW, (m > 0 && t >= 2) ? 32'h4 : NIL, 32'h4);
      end
    end
    // Counter frozen while disabled, then runs into the match
    wr(`HPC_OFS_CTRL, 32'h0000_0001);
    wr(`HPC_OFS_CTRL, 32'h0000_0003);
    wr(`HPC_OFS_COUNT, 32'h0000_0005);
    idle(2);
    wr(`HPC_OFS_CTRL, 32'h0000_0001);
    idle(100);
    rd(`HPC_OFS_COUNT, 32'h0000_0005, ALL);
    wr(`HPC_OFS_MATCH, 32'h0000_0007);
    wr(`HPC_OFS_MASK, 32'h0000_0008);
    wr(`HPC_OFS_CLEAR, 32'h0000_007F);
    wr(`HPC_OFS_CTRL, 32'h0000_0003);
    idle(70);
    rd(`HPC_OFS_COUNT, 32'h0000_0007, ALL);
    rd(`HPC_OFS_MATCH, 32'h0000_0007, ALL);
    rd(`HPC_OFS_RAW, 32'h0000_0008, 32'h0000_0008);
    chk({31'h0, IRQ}, 32'h1);
    // Hibernate with wake set up first, wake by pin
    band <= 3'h0;
    wr(`HPC_OFS_BATTERY, NIL);
    wr(`HPC_OFS_WAKE, 32'h0000_0009);
    wr(`HPC_OFS_CTRL, 32'h0000_0005);
    wait_en(1'b0);
    idle(10);
    pulse(0);
    wait_en(1'b1);
    rd(`HPC_OFS_CTRL, 32'h0000_0001, 32'h0000_0001);
    rd(8'h7C, 32'h0123_4567, ALL);
    // Abort while the battery is low, then a normal entry and gpio wake
    band <= 3'h3;
    wr(`HPC_OFS_BATTERY, 32'h0000_000E);
    idle(4);
    wr(`HPC_OFS_CTRL, 32'h0000_0005);
    idle(4);
    chk({31'h0, REG_EN}, 32'h1);
    band <= 3'h0;
    idle(4);
    wr(`HPC_OFS_CLEAR, 32'h0000_007F);
    idle(2);
    wr(`HPC_OFS_CTRL, 32'h0000_0005);
    wait_en(1'b0);
    pulse(2);
    wait_en(1'b1);
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #200000;
    fail_count++;
    give_verdict();
  end
endmodule : hpc_top_tb_top
